//--- dv/flash_link_assertions.sv
`timescale 1ns/10ps
module flash_link_assertions (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       selN,
  input wire logic       sclk,
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOe,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOe
);
  // *****
  // Lane ownership and edges
  // *****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_SEL_IDLE:
    assert property (selN [*8] |-> devOe == 4'h0)
    else $error("Lanes driven while deselected");
  AST_SEL_ABORT:
    assert property ($rose(selN) |-> ##[1:8] devOe == 4'h0)
    else $error("Stream not dropped");
  AST_DEV_ON_FALL:
    assert property ($changed(devOut & devOe) && !selN |-> !sclk)
    else $error("Device lane changed with clock high");
  AST_HOST_ON_FALL:
    assert property ($changed(hostOut) && !selN |-> !sclk)
    else $error("Host lane changed with clock high");
  AST_CLK_IDLE:
    assert property (selN |-> !sclk)
    else $error("Clock high outside frame");
  AST_NO_FIGHT:
    assert property ((devOe & hostOe) == 4'h0)
    else $error("Both ends drive a lane");
  AST_LANE_SET:
    assert property (devOe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("Odd lane set driven");
  AST_CMD_QUIET:
    assert property ($fell(selN) |-> (devOe == 4'h0) [*8])
    else $error("Device drives at frame start");
endmodule : flash_link_assertions

//--- dv/serial_flash_read_commands_tb_top.sv
`timescale 1ns/10ps
module serial_flash_read_commands_tb_top
  import flash_rd_pkg::*;
;
  typedef struct packed {
    logic [31:0] c;
    logic [23:0] a;
    logic [3:0]  f;
  } row_t;
  // *****
  // Rows: command word, address, {quad, busy, kind}
  // *****
  row_t rows [15] = '{
    '{32'h0000_0003, 24'h00_12FF, 4'h0},
    '{32'h0000_000B, 24'h05_00FE, 4'h0},
    '{32'h0000_003B, 24'h00_12FF, 4'h0},
    '{32'h0000_006B, 24'h00_12FF, 4'h8},
    '{32'h0000_00EB, 24'h00_12FF, 4'h8},
    '{32'h0001_000B, 24'h00_12FF, 4'h8},
    '{32'h0001_00EB, 24'h00_12FF, 4'h8},
    '{32'h0007_000B, 24'h00_12FF, 4'h8},
    '{32'h0001_0003, 24'h00_12FF, 4'h9},
    '{32'h0000_006B, 24'h00_12FF, 4'h1},
    '{32'h0000_0003, 24'h00_12FF, 4'h5},
    '{32'h0000_0005, 24'h00_12FF, 4'h6},
    '{32'h0000_20BB, 24'h00_12FF, 4'h0},
    '{32'h0008_FFBB, 24'h07_80FF, 4'h0},
    '{32'h0000_0003, 24'h00_12FF, 4'h0}
  };
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        busy = 1'b0;
  logic        quadEnable = 1'b0;
  logic        fourWireMode = 1'b0;
  logic        dummySelWr = 1'b0;
  logic        pready;
  logic        pslverr;
  logic        e;
  logic [1:0]  dummySel = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  statusByte = 8'hC6;
  logic [7:0]  memData;
  logic [23:0] memAddr;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] d;
  int          bad_count = 0;
  int          tests_run = 0;

  assign memData = memAddr[7:0] ^ memAddr[15:8];
  always #2 ref_clk = ~ref_clk;

  flash_link_if u_flash_link_if ();
  flash_dev u_flash_dev (
    .ref_clk(ref_clk),
    .reset(reset),
    .link(u_flash_link_if.dev),
    .memData(memData),
    .statusByte(statusByte),
    .busy(busy),
    .quadEnable(quadEnable),
    .fourWireMode(fourWireMode),
    .dummySel(dummySel),
    .dummySelWr(dummySelWr),
    .memAddr(memAddr)
  );
  flash_host u_flash_host (
    .ref_clk(ref_clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link(u_flash_link_if.host)
  );
  flash_link_assertions u_flash_link_assertions (
    .ref_clk(ref_clk),
    .reset(reset),
    .selN(u_flash_link_if.selN),
    .sclk(u_flash_link_if.sclk),
    .hostOut(u_flash_link_if.hostOut),
    .hostOe(u_flash_link_if.hostOe),
    .devOut(u_flash_link_if.devOut),
    .devOe(u_flash_link_if.devOe)
  );

  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    tests_run++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    dummySelWr <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] want(input row_t r, input logic [23:0] o);
    logic [23:0] x;
    x = r.a + o;
    if (r.f[1:0] == 2'h1) return 8'hFF;
    if (r.f[1:0] == 2'h2) return statusByte;
    return x[7:0] ^ x[15:8];
  endfunction : want

  task automatic run(input row_t r);
    quadEnable <= r.f[3];
    busy <= r.f[2];
    fourWireMode <= r.c[16];
    dummySel <= r.c[18:17];
    dummySelWr <= r.c[18:17] != 2'h0;
    apb(1'b1, REG_CMD, r.c, d, e);
    apb(1'b1, REG_ADDR, {8'h00, r.a}, d, e);
    apb(1'b1, REG_CTRL, 32'h0000_0001, d, e);
    for (int i = 0; i < 2; i++) begin
      d = 32'h0000_0000;
      for (int n = 0; n < 3000 && d[8] !== 1'b1; n++)
        apb(1'b0, REG_DATA, 32'h0000_0000, d, e);
      chk({7'h00, d[8]}, 8'h01);
      chk(d[7:0], want(r, 24'(i)));
    end
    // Stop, wait for idle, then drop any byte left behind
    apb(1'b1, REG_CTRL, 32'h0000_0002, d, e);
    d = 32'h0000_0001;
    for (int n = 0; n < 3000 && d[0] !== 1'b0; n++)
      apb(1'b0, REG_CTRL, 32'h0000_0000, d, e);
    chk({7'h00, d[0]}, 8'h00);
    apb(1'b0, REG_DATA, 32'h0000_0000, d, e);
  endtask : run

  // Exit frame: ones on lane 0, no data, link must go idle
  task automatic exitFrame(input logic [31:0] c);
    apb(1'b1, REG_CMD, c, d, e);
    apb(1'b1, REG_CTRL, 32'h0000_0001, d, e);
    d = 32'h0000_0001;
    for (int n = 0; n < 3000 && d[0] !== 1'b0; n++)
      apb(1'b0, REG_CTRL, 32'h0000_0000, d, e);
    chk({7'h00, d[0]}, 8'h00);
  endtask : exitFrame

  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  initial begin
    #300_000;
    bad_count++;
    results();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({4'h0, u_flash_link_if.selN, u_flash_link_if.sclk,
         |u_flash_link_if.devOe, |u_flash_link_if.hostOe}, 8'h08);
    // Unmapped register answers with an error and zero
    apb(1'b0, 8'h10, 32'h0000_0000, d, e);
    chk({7'h00, e}, 8'h01);
    chk(d[7:0], 8'h00);
    foreach (rows[i]) run(rows[i]);
    // Reset after the row runs: link idles, four-wire dummies back to two
    reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({4'h0, u_flash_link_if.selN, u_flash_link_if.sclk,
         |u_flash_link_if.devOe, |u_flash_link_if.hostOe}, 8'h08);
    @(posedge ref_clk);
    run('{32'h0001_000B, 24'h00_12FF, 4'h8});
    // Exit frames drop continuous mode before a plain read
    run('{32'h0000_20BB, 24'h00_12FF, 4'h0});
    exitFrame(32'h0030_0000);
    run('{32'h0000_0003, 24'h00_12FF, 4'h0});
    run('{32'h0000_20EB, 24'h00_12FF, 4'h8});
    exitFrame(32'h0010_0000);
    run('{32'h0000_0003, 24'h00_12FF, 4'h0});
    results();
  end
endmodule : serial_flash_read_commands_tb_top

//--- hdl/flash_dev.sv
`timescale 1ns/10ps
module flash_dev
  import flash_rd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  flash_link_if.dev        link,
  input  wire logic [7:0]  memData,
  input  wire logic [7:0]  statusByte,
  input  wire logic        busy,
  input  wire logic        quadEnable,
  input  wire logic        fourWireMode,
  input  wire logic [1:0]  dummySel,
  input  wire logic        dummySelWr,
  output logic      [23:0] memAddr
);

  typedef enum logic [2:0] {
    D_IDLE, D_CMD, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_IGNORE
  } dev_state_t;

  // ****************************************************
  // Pin synchronisers and clock edge detection
  // ****************************************************
  logic [2:0] selS_r;
  logic [2:0] clkS_r;
  logic [3:0] laneA_r;
  logic [3:0] laneB_r;
  logic       selHigh;
  logic       sclkRise;
  logic       sclkFall;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      selS_r  <= 3'h7;
      clkS_r  <= 3'h0;
      laneA_r <= 4'hF;
      laneB_r <= 4'hF;
    end else begin
      selS_r  <= {selS_r[1:0], link.selN};
      clkS_r  <= {clkS_r[1:0], link.sclk};
      laneA_r <= link.lane;
      laneB_r <= laneA_r;
    end
  end

  assign selHigh  = selS_r[1];
  assign sclkRise = clkS_r[1] & ~clkS_r[2];
  assign sclkFall = ~clkS_r[1] & clkS_r[2];

  // ****************************************************
  // Command engine
  // ****************************************************
  dev_state_t  st_r,     st_nxt;
  logic [5:0]  cnt_r,    cnt_nxt;
  logic [23:0] sh_r,     sh_nxt;
  fmt_t        fmt_r,    fmt_nxt;
  logic [7:0]  op_r,     op_nxt;
  logic [23:0] adr_r,    adr_nxt;
  logic [7:0]  ob_r,     ob_nxt;
  logic [3:0]  oc_r,     oc_nxt;
  logic [3:0]  out_r,    out_nxt;
  logic [3:0]  oe_r,     oe_nxt;
  logic        cont_r,   cont_nxt;
  logic [7:0]  contOp_r, contOp_nxt;
  logic [1:0]  dsel_r,   dsel_nxt;
  logic [2:0]  inW;
  logic [2:0]  phW;
  logic [23:0] shNew;
  fmt_t        fmtCmd;
  logic [7:0]  byteOut;

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    fmt_nxt    = fmt_r;
    op_nxt     = op_r;
    adr_nxt    = adr_r;
    ob_nxt     = ob_r;
    oc_nxt     = oc_r;
    out_nxt    = out_r;
    oe_nxt     = oe_r;
    cont_nxt   = cont_r;
    contOp_nxt = contOp_r;
    dsel_nxt   = dummySelWr ? dummySel : dsel_r;
    inW        = fourWireMode ? LANES_4 : LANES_1;
    phW        = (st_r == D_CMD) ? inW : fmt_r.addrW;
    shNew      = shiftIn(sh_r, laneB_r, phW);
    fmtCmd     = fmtOf(shNew[7:0], fourWireMode, dsel_r);
    byteOut    = (oc_r == 4'h0) ? (fmt_r.isStatus ? statusByte : memData)
                                : ob_r;
    if (selHigh) begin
      st_nxt  = D_IDLE;
      oe_nxt  = 4'h0;
      cnt_nxt = 6'h00;
      oc_nxt  = 4'h0;
    end else begin
      unique case (st_r)
        D_IDLE: begin
          if (cont_r) begin
            fmt_nxt = fmtOf(contOp_r, fourWireMode, dsel_r);
            op_nxt  = contOp_r;
            st_nxt  = busy ? D_IGNORE : D_ADDR;
          end else begin
            st_nxt = D_CMD;
          end
        end
        D_CMD: if (sclkRise) begin
          sh_nxt  = shNew;
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_nxt == clocksFor(BITS_CMD, inW)) begin
            cnt_nxt = 6'h00;
            op_nxt  = shNew[7:0];
            fmt_nxt = fmtCmd;
            if (!fmtCmd.valid || (fmtCmd.needQuad && !quadEnable)) begin
              st_nxt = D_IGNORE;
            end else if (busy && !fmtCmd.isStatus) begin
              st_nxt = D_IGNORE;
            end else if (!fmtCmd.hasAddr) begin
              st_nxt = D_DATA;
            end else begin
              st_nxt = D_ADDR;
            end
          end
        end
        D_ADDR: if (sclkRise) begin
          sh_nxt  = shNew;
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_nxt == clocksFor(BITS_ADDR, fmt_r.addrW)) begin
            cnt_nxt = 6'h00;
            adr_nxt = shNew;
            if (fmt_r.hasMode) begin
              st_nxt = D_MODE;
            end else if (fmt_r.dummy != 4'h0) begin
              st_nxt = D_DUMMY;
            end else begin
              st_nxt = D_DATA;
            end
          end
        end
        D_MODE: if (sclkRise) begin
          sh_nxt  = shNew;
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_nxt == clocksFor(BITS_MODE, fmt_r.addrW)) begin
            cnt_nxt    = 6'h00;
            cont_nxt   = shNew[CONT_HI:CONT_LO] == CONT_KEEP;
            contOp_nxt = op_r;
            st_nxt     = (fmt_r.dummy != 4'h0) ? D_DUMMY : D_DATA;
          end
        end
        D_DUMMY: if (sclkRise) begin
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_nxt == {2'h0, fmt_r.dummy}) begin
            cnt_nxt = 6'h00;
            st_nxt  = D_DATA;
          end
        end
        D_DATA: if (sclkFall) begin
          if (oc_r == 4'h0 && !fmt_r.isStatus) begin
            adr_nxt = adr_r + 24'h1;
          end
          ob_nxt = byteOut << fmt_r.dataW;
          oc_nxt = ((oc_r == 4'h0) ? 4'h8 : oc_r) - {1'b0, fmt_r.dataW};
          if (fmt_r.dataW == LANES_4) begin
            out_nxt = byteOut[7:4];
            oe_nxt  = 4'hF;
          end else if (fmt_r.dataW == LANES_2) begin
            out_nxt = {2'h0, byteOut[7:6]};
            oe_nxt  = 4'h3;
          end else begin
            out_nxt = {2'h0, byteOut[7], 1'b0};
            oe_nxt  = 4'h2;
          end
        end
        D_IGNORE: st_nxt = D_IGNORE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r     <= D_IDLE;
      cnt_r    <= 6'h00;
      sh_r     <= 24'h0;
      fmt_r    <= '0;
      op_r     <= 8'h00;
      adr_r    <= 24'h0;
      ob_r     <= 8'h00;
      oc_r     <= 4'h0;
      out_r    <= 4'h0;
      oe_r     <= 4'h0;
      cont_r   <= 1'b0;
      contOp_r <= 8'h00;
      dsel_r   <= DUMMY_SEL_RST;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      fmt_r    <= fmt_nxt;
      op_r     <= op_nxt;
      adr_r    <= adr_nxt;
      ob_r     <= ob_nxt;
      oc_r     <= oc_nxt;
      out_r    <= out_nxt;
      oe_r     <= oe_nxt;
      cont_r   <= cont_nxt;
      contOp_r <= contOp_nxt;
      dsel_r   <= dsel_nxt;
    end
  end

  assign link.devOut = out_r;
  assign link.devOe  = oe_r;
  assign memAddr     = adr_r;

endmodule : flash_dev

//--- hdl/flash_host.sv
`timescale 1ns/10ps
module flash_host
  import flash_rd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  flash_link_if.host       link
);

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_CMD, H_ADDR, H_MODE, H_DUMMY, H_DATA, H_END
  } host_state_t;

  function automatic logic [3:0] spread(input logic [3:0] v,
                                        input logic [2:0] w);
    if (w == LANES_4) begin
      return v;
    end else if (w == LANES_2) begin
      return {2'h0, v[3:2]};
    end
    return {3'h0, v[3]};
  endfunction : spread

  // ****************************************************
  // APB registers
  // ****************************************************
  logic [31:0] cmd_r,  cmd_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [31:0] prd_r,  prd_nxt;
  logic        access;
  logic        mapped;
  logic        wrCtrl;
  logic        rdData;

  host_state_t st_r,      st_nxt;
  logic        stopReq_r, stop_nxt;
  logic [7:0]  rx_r,      rx_nxt;
  logic        rxValid_r, rxValid_nxt;

  assign access = psel & penable;
  assign mapped = paddr == REG_CMD || paddr == REG_ADDR
               || paddr == REG_CTRL || paddr == REG_DATA;
  assign wrCtrl = access & pwrite & (paddr == REG_CTRL);
  assign rdData = access & !pwrite & (paddr == REG_DATA)
                & prd_r[DATA_VALID];

  always_comb begin
    cmd_nxt  = cmd_r;
    addr_nxt = addr_r;
    prd_nxt  = prd_r;
    if (access && pwrite && paddr == REG_CMD) begin
      cmd_nxt = pwdata;
    end
    if (access && pwrite && paddr == REG_ADDR) begin
      addr_nxt = pwdata[23:0];
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CMD:  prd_nxt = cmd_r;
        REG_ADDR: prd_nxt = {8'h00, addr_r};
        REG_CTRL: prd_nxt = {30'h0, stopReq_r, st_r != H_IDLE};
        REG_DATA: prd_nxt = {23'h0, rxValid_r, rx_r};
        default:  prd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_r  <= 32'h0;
      addr_r <= 24'h0;
      prd_r  <= 32'h0;
    end else begin
      cmd_r  <= cmd_nxt;
      addr_r <= addr_nxt;
      prd_r  <= prd_nxt;
    end
  end

  assign prdata  = prd_r;
  assign pready  = 1'b1;
  assign pslverr = access & !mapped;

  // ****************************************************
  // Link sequencer
  // ****************************************************
  logic [3:0]  laneA_r;
  logic [3:0]  laneB_r;
  logic        selN_r,   selN_nxt;
  logic        sclk_r,   sclk_nxt;
  logic [4:0]  div_r,    div_nxt;
  logic [5:0]  cnt_r,    cnt_nxt;
  logic [23:0] tx_r,     tx_nxt;
  logic [2:0]  txW_r,    txW_nxt;
  logic [3:0]  oe_r,     oe_nxt;
  logic [23:0] rxSh_r,   rxSh_nxt;
  logic [3:0]  rxBits_r, rxBits_nxt;
  fmt_t        fmt;
  logic        tick;
  logic        goPhase;
  logic        exitCmd;
  logic [2:0]  cmdW;
  logic [5:0]  phLen;
  host_state_t nextPh;
  logic [2:0]  wNext;

  assign fmt     = fmtOf(cmd_r[7:0], cmd_r[F_FOUR],
                         cmd_r[F_DSEL_LO+1:F_DSEL_LO]);
  assign tick    = div_r == SCLK_HALF_CYC - 5'h1;
  assign exitCmd = cmd_r[F_EXIT];
  assign cmdW    = (cmd_r[F_FOUR] && !exitCmd) ? LANES_4 : LANES_1;

  always_comb begin
    st_nxt      = st_r;
    selN_nxt    = selN_r;
    sclk_nxt    = sclk_r;
    cnt_nxt     = cnt_r;
    tx_nxt      = tx_r;
    txW_nxt     = txW_r;
    oe_nxt      = oe_r;
    rxSh_nxt    = rxSh_r;
    rxBits_nxt  = rxBits_r;
    rx_nxt      = rx_r;
    rxValid_nxt = rxValid_r & !rdData;
    stop_nxt    = stopReq_r | (wrCtrl & pwdata[CTRL_STOP]);
    div_nxt     = (st_r == H_IDLE || tick) ? 5'h0 : div_r + 5'h1;
    goPhase     = 1'b0;
    phLen       = 6'h00;
    nextPh      = H_END;
    wNext       = LANES_1;
    unique case (st_r)
      H_SETUP: nextPh = (cmd_r[F_SKIP] && !exitCmd) ? H_ADDR : H_CMD;
      H_CMD: begin
        phLen  = !exitCmd ? clocksFor(BITS_CMD, cmdW)
               : cmd_r[F_EXIT_LONG] ? EXIT_LONG : EXIT_SHORT;
        nextPh = exitCmd ? H_END : fmt.hasAddr ? H_ADDR : H_DATA;
      end
      H_ADDR: begin
        phLen  = clocksFor(BITS_ADDR, fmt.addrW);
        nextPh = fmt.hasMode ? H_MODE
               : (fmt.dummy != 4'h0) ? H_DUMMY : H_DATA;
      end
      H_MODE: begin
        phLen  = clocksFor(BITS_MODE, fmt.addrW);
        nextPh = (fmt.dummy != 4'h0) ? H_DUMMY : H_DATA;
      end
      H_DUMMY: begin
        phLen  = {2'h0, fmt.dummy};
        nextPh = H_DATA;
      end
      default: phLen = 6'h00;
    endcase
    if (nextPh == H_CMD) begin
      wNext = cmdW;
    end else if (nextPh == H_ADDR || nextPh == H_MODE) begin
      wNext = fmt.addrW;
    end
    unique case (st_r)
      H_IDLE: if (wrCtrl && pwdata[CTRL_START]) begin
        selN_nxt = 1'b0;
        stop_nxt = 1'b0;
        st_nxt   = H_SETUP;
      end
      H_SETUP: goPhase = tick;
      H_END: if (tick) begin
        st_nxt   = H_IDLE;
        stop_nxt = 1'b0;
      end
      H_DATA: if (tick) begin
        if (sclk_r) begin
          sclk_nxt = 1'b0;
        end else if (rxBits_r == 4'h0 && stopReq_r) begin
          st_nxt   = H_END;
          selN_nxt = 1'b1;
        end else if (!(rxBits_r == 4'h0 && rxValid_r)) begin
          sclk_nxt   = 1'b1;
          rxSh_nxt   = shiftIn(rxSh_r, (fmt.dataW == LANES_1) ?
                         {3'h0, laneB_r[1]} : laneB_r, fmt.dataW);
          rxBits_nxt = rxBits_r + {1'b0, fmt.dataW};
          if (rxBits_nxt == 4'h8) begin
            rxBits_nxt  = 4'h0;
            rx_nxt      = rxSh_nxt[7:0];
            rxValid_nxt = 1'b1;
          end
        end
      end
      default: if (tick) begin
        if (!sclk_r) begin
          sclk_nxt = 1'b1;
          cnt_nxt  = cnt_r + 6'h01;
        end else begin
          sclk_nxt = 1'b0;
          if (cnt_r == phLen) begin
            goPhase = 1'b1;
          end else begin
            tx_nxt = tx_r << txW_r;
          end
        end
      end
    endcase
    if (goPhase) begin
      st_nxt     = nextPh;
      cnt_nxt    = 6'h00;
      txW_nxt    = wNext;
      rxBits_nxt = 4'h0;
      oe_nxt     = 4'h0;
      case (nextPh)
        H_CMD:   tx_nxt = exitCmd ? 24'hFF_FFFF : {cmd_r[7:0], 16'h0000};
        H_ADDR:  tx_nxt = addr_r;
        H_MODE:  tx_nxt = {cmd_r[F_MODE_LO+7:F_MODE_LO], 16'h0000};
        default: tx_nxt = tx_r;
      endcase
      if (nextPh == H_CMD || nextPh == H_ADDR || nextPh == H_MODE) begin
        oe_nxt = spread(4'hF, wNext);
      end
      if (nextPh == H_END) begin
        selN_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      laneA_r   <= 4'hF;
      laneB_r   <= 4'hF;
      st_r      <= H_IDLE;
      selN_r    <= 1'b1;
      sclk_r    <= 1'b0;
      div_r     <= 5'h0;
      cnt_r     <= 6'h00;
      tx_r      <= 24'h0;
      txW_r     <= LANES_1;
      oe_r      <= 4'h0;
      rxSh_r    <= 24'h0;
      rxBits_r  <= 4'h0;
      rx_r      <= 8'h00;
      rxValid_r <= 1'b0;
      stopReq_r <= 1'b0;
    end else begin
      laneA_r   <= link.lane;
      laneB_r   <= laneA_r;
      st_r      <= st_nxt;
      selN_r    <= selN_nxt;
      sclk_r    <= sclk_nxt;
      div_r     <= div_nxt;
      cnt_r     <= cnt_nxt;
      tx_r      <= tx_nxt;
      txW_r     <= txW_nxt;
      oe_r      <= oe_nxt;
      rxSh_r    <= rxSh_nxt;
      rxBits_r  <= rxBits_nxt;
      rx_r      <= rx_nxt;
      rxValid_r <= rxValid_nxt;
      stopReq_r <= stop_nxt;
    end
  end

  assign link.selN    = selN_r;
  assign link.sclk    = sclk_r;
  assign link.hostOut = spread(tx_r[23:20], txW_r);
  assign link.hostOe  = oe_r;

endmodule : flash_host

//--- hdl/flash_link_if.sv
`timescale 1ns/10ps
interface flash_link_if;
  logic       selN;
  logic       sclk;
  logic [3:0] hostOut;
  logic [3:0] hostOe;
  logic [3:0] devOut;
  logic [3:0] devOe;
  logic [3:0] lane;

  // Pulled-up lanes: device drive wins, undriven lanes read one
  assign lane = (devOut & devOe) | (hostOut & hostOe & ~devOe)
              | ~(devOe | hostOe);

  modport dev  (input selN, input sclk, input lane,
                output devOut, output devOe);
  modport host (output selN, output sclk, output hostOut,
                output hostOe, input lane);
endinterface : flash_link_if

//--- hdl/flash_rd_pkg.sv
package flash_rd_pkg;

  // ****************************************************
  // Opcodes and lane widths
  // ****************************************************
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FAST     = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO  = 8'hEB;
  localparam logic [7:0] OP_STATUS   = 8'h05;
  localparam logic [2:0] LANES_1     = 3'h1;
  localparam logic [2:0] LANES_2     = 3'h2;
  localparam logic [2:0] LANES_4     = 3'h4;

  // ****************************************************
  // Phase lengths and mode bits
  // ****************************************************
  localparam logic [5:0] BITS_CMD      = 6'h08;
  localparam logic [5:0] BITS_ADDR     = 6'h18;
  localparam logic [5:0] BITS_MODE     = 6'h08;
  localparam logic [5:0] EXIT_SHORT    = 6'h08;
  localparam logic [5:0] EXIT_LONG     = 6'h10;
  localparam logic [3:0] DUMMY_STD     = 4'h8;
  localparam logic [3:0] DUMMY_QIO     = 4'h4;
  localparam logic [3:0] MODE_AS_DUMMY = 4'h2;
  localparam logic [1:0] DUMMY_SEL_RST = 2'h0;
  localparam logic [1:0] CONT_KEEP     = 2'h2;
  localparam int         CONT_HI       = 5;
  localparam int         CONT_LO       = 4;

  // ****************************************************
  // Link clock and host registers
  // ****************************************************
  localparam int         REF_PERIOD_NS = 4;
  localparam int         SCLK_HALF_NS  = 80;
  localparam logic [4:0] SCLK_HALF_CYC = 5'(SCLK_HALF_NS / REF_PERIOD_NS);
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_ADDR      = 8'h04;
  localparam logic [7:0] REG_CTRL      = 8'h08;
  localparam logic [7:0] REG_DATA      = 8'h0C;
  localparam int         F_MODE_LO     = 8;
  localparam int         F_FOUR        = 16;
  localparam int         F_DSEL_LO     = 17;
  localparam int         F_SKIP        = 19;
  localparam int         F_EXIT        = 20;
  localparam int         F_EXIT_LONG   = 21;
  localparam int         CTRL_START    = 0;
  localparam int         CTRL_STOP     = 1;
  localparam int         DATA_VALID    = 8;

  typedef struct packed {
    logic       valid;
    logic       needQuad;
    logic       isStatus;
    logic       hasAddr;
    logic       hasMode;
    logic [2:0] addrW;
    logic [2:0] dataW;
    logic [3:0] dummy;
  } fmt_t;

  // Frame layout of each read command
  function automatic fmt_t fmtOf(input logic [7:0] op,
                                 input logic       four,
                                 input logic [1:0] dsel);
    fmt_t       f;
    logic [3:0] qDum;
    qDum      = {1'b0, dsel, 1'b0} + MODE_AS_DUMMY;
    f         = '0;
    f.valid   = 1'b1;
    f.hasAddr = 1'b1;
    f.addrW   = four ? LANES_4 : LANES_1;
    f.dataW   = f.addrW;
    case (op)
      OP_READ: f.valid = !four;
      OP_FAST: f.dummy = four ? qDum : DUMMY_STD;
      OP_DUAL_OUT: begin
        f.valid = !four;
        f.dataW = LANES_2;
        f.dummy = DUMMY_STD;
      end
      OP_QUAD_OUT: begin
        f.valid    = !four;
        f.needQuad = 1'b1;
        f.dataW    = LANES_4;
        f.dummy    = DUMMY_STD;
      end
      OP_DUAL_IO: begin
        f.valid   = !four;
        f.addrW   = LANES_2;
        f.dataW   = LANES_2;
        f.hasMode = 1'b1;
      end
      OP_QUAD_IO: begin
        f.needQuad = 1'b1;
        f.addrW    = LANES_4;
        f.dataW    = LANES_4;
        f.hasMode  = 1'b1;
        f.dummy    = four ? qDum - MODE_AS_DUMMY : DUMMY_QIO;
      end
      OP_STATUS: begin
        f.isStatus = 1'b1;
        f.hasAddr  = 1'b0;
      end
      default: f.valid = 1'b0;
    endcase
    return f;
  endfunction : fmtOf

  // Shift w lanes into the low end, lane 0 least significant
  function automatic logic [23:0] shiftIn(input logic [23:0] sh,
                                          input logic [3:0]  ln,
                                          input logic [2:0]  w);
    if (w == LANES_4) begin
      return {sh[19:0], ln};
    end else if (w == LANES_2) begin
      return {sh[21:0], ln[1:0]};
    end
    return {sh[22:0], ln[0]};
  endfunction : shiftIn

  function automatic logic [5:0] clocksFor(input logic [5:0] bits,
                                           input logic [2:0] w);
    if (w == LANES_4) begin
      return bits >> 2;
    end else if (w == LANES_2) begin
      return bits >> 1;
    end
    return bits;
  endfunction : clocksFor

endpackage : flash_rd_pkg
